// [design/monitor_limit_flagging.sv]
// Purpose: channel rotation, result store, limit flags, resistor table,
//          open-drain buffers and two-wire register access
// Assumes: converter answers on conv_data for the channel on conv_chan
// Notes:   two-wire pins are sampled by sys_clk through two flip-flops
`timescale 1ns/1ps
// How it works
// - each stored conversion sets its channel's sticky done bit
// - every channel has alarm and warning pairs for above-high and below-low
// - per-channel interrupt enables route limit events to limit_event
// - two resistor bytes per 2 degree step from -40 to +102 degrees
// - two logic inputs reproduced on open-drain outputs
// - first open-drain output also asserts on enabled limit events
// - results are 16-bit words, 13 significant bits left-justified
// - low-resolution build forces the three result LSBs to zero
// - channels refreshed in fixed rotating order, each once per frame
// - limit checks run automatically and set flags within one slot
// - temperature spans 8000 to 7ff8, others 0000 to fff8
// - temperature compared signed, other channels unsigned
// - lsb weights for supply and analog inputs are host scaling only
// - write-protect pin low never blocks writes; pull-up reads as protect
// - registers move both ways over the two-wire bus, host clocks it
// - frame lasts about 30 ms, never above 45 ms
// - temperature indexes table entry 80h to c7h, clamped at both ends
// - with table indexing off, resistors follow the two manual bytes
module monitor_limit_flagging
  import monitor_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = monitor_pkg::FRAME_CYC,
  parameter bit          LOW_RES      = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic      [2:0]  conv_chan,
  input  wire logic [15:0] conv_data,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        logic_in_a,
  input  wire logic        logic_in_b,
  output logic             fault_out_a_oe,
  output logic             fault_out_b_oe,
  input  wire logic        write_protect_pin,
  output logic      [7:0]  res_pos_0,
  output logic      [7:0]  res_pos_1,
  output logic             limit_event
);
  import monitor_pkg::*;

  localparam int unsigned SLOT_CYC = FRAME_CYCLES / NCH;

  // ----------------------------------------------------------------
  // pin synchronisers {wp, in_b, in_a, sda, scl}
  // ----------------------------------------------------------------
  logic [4:0] meta, sync, sync_d;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta   <= 5'h13;
      sync   <= 5'h13;
      sync_d <= 5'h13;
    end else begin
      meta   <= {write_protect_pin, logic_in_b, logic_in_a, sda_in, scl};
      sync   <= meta;
      sync_d <= sync;
    end
  end
  wire scl_s     = sync[0];
  wire sda_s     = sync[1];
  wire scl_rise  = scl_s & ~sync_d[0];
  wire scl_fall  = ~scl_s & sync_d[0];
  wire start_c   = scl_s & sync_d[0] & sync_d[1] & ~sda_s;
  wire stop_c    = scl_s & sync_d[0] & ~sync_d[1] & sda_s;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] limit [20];
  logic [15:0] result [NCH];
  logic [15:0] lut [LUT_DEPTH];
  logic [9:0]  alarm, warn;
  logic [4:0]  done, int_en, chan_viol;
  logic [2:0]  cfg;
  logic [15:0] manual;
  logic [6:0]  temp_idx;
  logic [31:0] slot_cnt;
  logic [2:0]  cur;
  link_state_e st;
  logic [4:0]  cnt;
  logic [15:0] sh, s_rd;
  logic        rw, sda_low, swr;
  logic [7:0]  sidx;

  // ----------------------------------------------------------------
  // channel rotation and store
  // ----------------------------------------------------------------
  wire store = (slot_cnt == SLOT_CYC - 1);
  wire [15:0] new_res = LOW_RES ? (conv_data & LOW_RES_MASK) : conv_data;
  wire is_temp = (cur == CH_TEMP);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slot_cnt <= 32'h0;
      cur      <= 3'h0;
    end else begin
      slot_cnt <= store ? 32'h0 : slot_cnt + 32'h1;
      if (store) cur <= (cur == CH_TEMP) ? 3'h0 : cur + 3'h1;
    end
  end
  assign conv_chan = cur;

  function automatic logic above(input logic [15:0] a, input logic [15:0] b,
                                 input logic sgn);
    above = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  wire [4:0] lb = 5'(cur * 4);
  wire a_hi = above(new_res, limit[lb], is_temp);
  wire a_lo = above(limit[lb + 5'h1], new_res, is_temp);
  wire w_hi = above(new_res, limit[lb + 5'h2], is_temp);
  wire w_lo = above(limit[lb + 5'h3], new_res, is_temp);

  // ----------------------------------------------------------------
  // register access: local port wins over the serial link
  // ----------------------------------------------------------------
  reg_req_s acc;
  assign acc.wr    = wr | swr;
  assign acc.addr  = wr ? addr : sidx;
  assign acc.wdata = wr ? wdata : sh;
  wire protect  = sync[4] & cfg[CFG_PROT];
  wire lim_hit  = acc.addr <= A_LIMIT_END;
  wire lut_hit  = (acc.addr >= A_LUT) && (acc.addr <= A_LUT_END);
  wire [7:0] lut_off = acc.addr - A_LUT;
  wire [4:0] done_clr = (acc.wr && acc.addr == A_DONE) ? acc.wdata[4:0] : 5'h0;
  wire [4:0] done_set = store ? 5'(5'h1 << cur) : 5'h0;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 20; i++) limit[i] <= 16'h0000;
    end else if (acc.wr && lim_hit && !protect) begin
      limit[acc.addr[4:0]] <= acc.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < LUT_DEPTH; i++) lut[i] <= LUT_RST;
    end else if (acc.wr && lut_hit && !protect) begin
      lut[lut_off[6:0]] <= acc.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) result[i] <= 16'h0000;
      alarm <= 10'h000;
      warn  <= 10'h000;
    end else if (store) begin
      result[cur] <= new_res;
      alarm[4'(2 * cur) +: 2] <= {a_lo, a_hi};
      warn[4'(2 * cur) +: 2]  <= {w_lo, w_hi};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      done   <= 5'h00;
      int_en <= INTEN_RST;
      cfg    <= CFG_RST;
      manual <= MANUAL_RST;
    end else begin
      done <= (done & ~done_clr) | done_set;
      if (acc.wr && acc.addr == A_INTEN) int_en <= acc.wdata[4:0];
      if (acc.wr && acc.addr == A_CFG) cfg <= acc.wdata[2:0];
      if (acc.wr && acc.addr == A_MANUAL && !protect) manual <= acc.wdata;
    end
  end

  // ----------------------------------------------------------------
  // limit routing and open-drain buffers
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_viol
      assign chan_viol[ch] = |alarm[2*ch +: 2] | |warn[2*ch +: 2];
    end
  endgenerate
  assign limit_event    = |(int_en & chan_viol);
  assign fault_out_a_oe = ~(sync[2] | (cfg[CFG_OUTA] & limit_event));
  assign fault_out_b_oe = ~sync[3];

  // ----------------------------------------------------------------
  // temperature indexed resistor table
  // ----------------------------------------------------------------
  wire signed [8:0] t_ofs = 9'($signed(new_res[15:8])) + TEMP_OFFSET;
  wire [7:0] t_half = 8'(t_ofs[8:1]);
  wire [6:0] next_idx = t_ofs[8] ? 7'h00 :
                        (t_half > 8'(LUT_LAST)) ? LUT_LAST : t_half[6:0];
  wire [15:0] next_pos = cfg[CFG_TEN] ? lut[temp_idx] : manual;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      temp_idx  <= 7'h00;
      res_pos_0 <= 8'h00;
      res_pos_1 <= 8'h00;
    end else begin
      if (store && is_temp) temp_idx <= next_idx;
      res_pos_0 <= next_pos[7:0];
      res_pos_1 <= next_pos[15:8];
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] rd_val(input logic [7:0] a);
    logic [7:0] r;
    r = a - A_RESULT;
    rd_val = 16'h0000;
    if (a <= A_LIMIT_END) rd_val = limit[a[4:0]];
    else if (a >= A_RESULT && a <= A_RESULT_END) rd_val = result[r[2:0]];
    else if (a >= A_LUT && a <= A_LUT_END) rd_val = lut[7'(a - A_LUT)];
    else if (a == A_ALARM) rd_val = {6'h00, alarm};
    else if (a == A_WARN) rd_val = {6'h00, warn};
    else if (a == A_DONE) rd_val = {11'h000, done};
    else if (a == A_INTEN) rd_val = {11'h000, int_en};
    else if (a == A_CFG) rd_val = {13'h0, cfg};
    else if (a == A_MANUAL) rd_val = manual;
    else if (a == A_POS) rd_val = {res_pos_1, res_pos_0};
    else if (a == A_STATUS) rd_val = {11'h000, sync[4:2], limit_event, st != S_IDLE};
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rstn) rdata <= 16'h0000;
    else rdata <= rd ? rd_val(addr) : 16'h0000;
  end

  // ----------------------------------------------------------------
  // two-wire slave: address byte {index, rw}, then one 16-bit word
  // ----------------------------------------------------------------
  always_comb s_rd = rd_val(sidx);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= S_IDLE;
      cnt <= 5'h00;
      sh <= 16'h0000;
      rw <= 1'b0;
      sda_low <= 1'b0;
      swr <= 1'b0;
      sidx <= 8'h00;
    end else begin
      swr <= 1'b0;
      if (start_c) begin
        st <= S_ADDR;
        cnt <= 5'h00;
        sda_low <= 1'b0;
      end else if (stop_c) begin
        st <= S_IDLE;
        sda_low <= 1'b0;
      end else begin
        unique case (st)
          S_IDLE: ;
          S_ADDR: begin
            if (scl_rise) begin
              sh <= {sh[14:0], sda_s};
              cnt <= cnt + 5'h01;
            end else if (scl_fall && cnt == 5'h08) begin
              st <= S_AACK;
              sda_low <= 1'b1;
              rw <= sh[0];
              sidx <= {1'b0, sh[7:1]};
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              st <= rw ? S_TX : S_RX;
              cnt <= 5'h00;
              sh <= rw ? {s_rd[14:0], 1'b0} : 16'h0000;
              sda_low <= rw & ~s_rd[15];
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt == 5'h0f) begin
                st <= S_IDLE;
                sda_low <= 1'b0;
              end else begin
                sda_low <= ~sh[15];
                sh <= {sh[14:0], 1'b0};
                cnt <= cnt + 5'h01;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              sh <= {sh[14:0], sda_s};
              cnt <= cnt + 5'h01;
            end else if (cnt == 5'h10) begin
              swr <= 1'b1;
              st <= S_IDLE;
            end
          end
        endcase
      end
    end
  end
  assign sda_oe  = sda_low;
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_done_sets: assert property (store |=> done[$past(cur)])
    else $error("done bit not set after store");
  a_alarm_high: assert property (store && a_hi |=> alarm[4'(2 * $past(cur))])
    else $error("alarm high flag missing");
  a_warn_low: assert property (store && !w_lo |=> !warn[4'(2 * $past(cur)) + 4'h1])
    else $error("warning low flag set without cause");
  a_int_route: assert property (store && a_hi && int_en[cur] |=>
                                limit_event || !int_en[$past(cur)])
    else $error("enabled limit event not routed");
  a_out_a_event: assert property (limit_event && cfg[CFG_OUTA] |-> !fault_out_a_oe)
    else $error("first output not asserted on limit event");
  a_buf_b_follow: assert property (fault_out_b_oe == !$past(logic_in_b, 2))
    else $error("second buffer does not follow input");
  a_rotate_order: assert property (store && cur == CH_TEMP |=> cur == 3'h0)
    else $error("rotation order broken");
  a_slot_bound: assert property (slot_cnt < SLOT_CYC)
    else $error("slot counter beyond frame share");
  a_low_res_mask: assert property (store && LOW_RES |=> result[$past(cur)][2:0] == 3'h0)
    else $error("low bits not masked");
  a_manual_pos: assert property (!cfg[CFG_TEN] ##1 !cfg[CFG_TEN] |->
                                 res_pos_0 == $past(manual[7:0]))
    else $error("manual position not applied");
  a_protect_hold: assert property (acc.wr && lim_hit && protect |=>
                                   limit[$past(acc.addr[4:0])] ==
                                   $past(limit[acc.addr[4:0]]))
    else $error("protected limit written");

  c_serial_read: cover property (st == S_TX ##1 st == S_IDLE);
  c_serial_write: cover property (swr);
  c_temp_clamp: cover property (store && is_temp && t_ofs[8]);
  c_limit_out: cover property (limit_event && !fault_out_a_oe);
endmodule

// [design/monitor_pkg.sv]
// Purpose: shared constants and types for the monitor and limit flag block
// Assumes: 40 MHz system clock, 16-bit register words
// Notes:   offsets are word indices on the local register port
package monitor_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned FRAME_US     = 30_000;
  localparam int unsigned FRAME_MAX_US = 45_000;
  localparam int unsigned FRAME_CYC    = FRAME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned NCH          = 5;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_LIMIT    = 8'h00;
  localparam logic [7:0] A_LIMIT_END = 8'h13;
  localparam logic [7:0] A_RESULT   = 8'h20;
  localparam logic [7:0] A_RESULT_END = 8'h24;
  localparam logic [7:0] A_ALARM    = 8'h28;
  localparam logic [7:0] A_WARN     = 8'h29;
  localparam logic [7:0] A_DONE     = 8'h2a;
  localparam logic [7:0] A_INTEN    = 8'h2b;
  localparam logic [7:0] A_CFG      = 8'h2c;
  localparam logic [7:0] A_MANUAL   = 8'h2d;
  localparam logic [7:0] A_STATUS   = 8'h2e;
  localparam logic [7:0] A_POS      = 8'h2f;
  localparam logic [7:0] A_LUT      = 8'h80;
  localparam logic [7:0] A_LUT_END  = 8'hc7;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_TEN  = 0;
  localparam int CFG_OUTA = 1;
  localparam int CFG_PROT = 2;
  localparam logic [2:0]  CFG_RST    = 3'h1;
  localparam logic [4:0]  INTEN_RST  = 5'h00;
  localparam logic [15:0] MANUAL_RST = 16'h0000;
  localparam logic [15:0] LUT_RST    = 16'h0000;
  localparam logic [2:0]  CH_TEMP    = 3'h4;
  localparam logic [15:0] LOW_RES_MASK = 16'hfff8;
  localparam logic signed [8:0] TEMP_OFFSET = 9'sh028;
  localparam logic [6:0] LUT_LAST   = 7'h47;
  localparam int unsigned LUT_DEPTH = 72;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
  } reg_req_s;
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_TX, S_RX} link_state_e;
endpackage

// [verif/twi_host.sv]
// Purpose: two-wire bus host model on the serial pins
// Assumes: 200 ns bit period, both lines pulled up when released
// Notes:   sda_pull high means the host pulls the data line low
`timescale 1ns/1ps
module twi_host (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // ----------------------------------------------------------------
  // bit and word transfers, host owns the clock
  // ----------------------------------------------------------------
  task automatic put(input logic b);
    #50 sda_pull = ~b;
    #50 scl = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic get(output logic b);
    #50 sda_pull = 1'b0;
    #50 scl = 1'b1;
    #50 b = sda;
    #50 scl = 1'b0;
  endtask
  // start, index and direction, ack, 16 bits msb first, stop
  task automatic xfer(input logic [6:0] idx, input logic rw,
                      inout logic [15:0] w, output logic ack);
    logic [7:0] hd;
    hd = {idx, rw};
    sda_pull = 1'b1;
    #50 scl = 1'b0;
    for (int i = 7; i >= 0; i--) put(hd[i]);
    get(ack);
    for (int i = 15; i >= 0; i--)
      if (rw) get(w[i]);
      else put(w[i]);
    #50 sda_pull = 1'b1;
    #50 scl = 1'b1;
    #50 sda_pull = 1'b0;
    #50;
  endtask
endmodule

// [verif/monitor_limit_flagging_tb.sv]
// Purpose: self-checking bench for the monitor and limit flag block
// Assumes: shortened frame, two-wire host model on the serial pins
// Notes:   conv_data follows conv_chan from a per-channel table
`timescale 1ns/1ps
module monitor_limit_flagging_tb;
  import monitor_pkg::*;
  localparam int unsigned FR = 50;
  logic        sys_clk;
  logic        rstn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        logic_in_a = 1'b0;
  logic        logic_in_b = 1'b0;
  logic        write_protect_pin = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] conv_data = 16'h0000;
  logic [15:0] rdata;
  logic [7:0]  res_pos_0, res_pos_1;
  logic [2:0]  conv_chan;
  logic        scl, sda_pull, sda_out, sda_oe;
  logic        fault_out_a_oe, fault_out_b_oe, limit_event;
  wire         sda = ~(sda_pull | sda_oe);
  logic [15:0] val [5] = '{16'hfff8, 16'h8000, 16'h1237, 16'h0000, 16'hd800};
  int          bad_count = 0;
  int          tests_run = 0;
  // ----------------------------------------------------------------
  // plumbing
  // ----------------------------------------------------------------
  monitor_limit_flagging #(.FRAME_CYCLES(FR), .LOW_RES(1'b1)) i_monitor_limit_flagging (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .conv_chan(conv_chan), .conv_data(conv_data), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .logic_in_a(logic_in_a),
    .logic_in_b(logic_in_b), .fault_out_a_oe(fault_out_a_oe),
    .fault_out_b_oe(fault_out_b_oe), .write_protect_pin(write_protect_pin),
    .res_pos_0(res_pos_0), .res_pos_1(res_pos_1), .limit_event(limit_event));
  twi_host i_twi_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) conv_data <= val[conv_chan];
  task automatic tally_and_finish;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic frame;
    repeat (FR + 10) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(rdata, 16'h0000);
    chk(16'(conv_chan), 16'h0000);
    chk(16'(limit_event), 16'h0000);
    chk(16'({sda_out, sda_oe}), 16'h0000);
    rchk(A_CFG, 16'h0001);
    rchk(A_INTEN, 16'h0000);
    rchk(A_STATUS, 16'h0010);
    $display("test reset done");
  endtask
  task automatic t_rotate;
    logic [2:0] p;
    int         n;
    p = conv_chan;
    for (int i = 0; i < 7; i++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        #1 n++;
      end while (conv_chan === p && n < 40);
      if (i > 0) chk(16'(n), 16'(FR / 5));
      chk(16'(conv_chan), (p == 3'h4) ? 16'h0000 : 16'(p + 3'h1));
      p = conv_chan;
    end
    $display("test rotate done");
  endtask
  task automatic t_results;
    logic [2:0] p;
    frame;
    for (int c = 0; c < 5; c++) rchk(A_RESULT + 8'(c), val[c] & LOW_RES_MASK);
    rchk(A_RESULT + 8'h02, 16'h1230);
    rchk(A_RESULT, 16'hfff8);
    rchk(A_DONE, 16'h001f);
    // clear right after a store, read back before the next one
    p = conv_chan;
    do begin
      @(posedge sys_clk);
      #1;
    end while (conv_chan === p);
    wr_reg(A_DONE, 16'h001f);
    rchk(A_DONE, 16'h0000);
    $display("test results done");
  endtask
  task automatic t_buffers;
    logic [1:0] v;
    for (int i = 3; i >= 0; i--) begin
      v = 2'(i);
      @(posedge sys_clk);
      logic_in_a <= v[0];
      logic_in_b <= v[1];
      repeat (4) @(posedge sys_clk);
      #1 chk(16'({fault_out_a_oe, fault_out_b_oe}), 16'({~v[0], ~v[1]}));
    end
    $display("test buffers done");
  endtask
  task automatic t_limits;
    for (int c = 0; c < 5; c++)
      for (int k = 0; k < 4; k++)
        wr_reg(8'(c * 4 + k), (c == 4) ? (k[0] ? 16'h8000 : 16'h7fff)
                                       : (k[0] ? 16'h0000 : 16'hffff));
    frame;
    rchk(A_ALARM, 16'h0000);
    rchk(A_WARN, 16'h0000);
    wr_reg(8'h04, 16'h4000);
    wr_reg(8'h13, 16'h0000);
    frame;
    rchk(A_ALARM, 16'h0004);
    rchk(A_WARN, 16'h0200);
    chk(16'(limit_event), 16'h0000);
    wr_reg(A_INTEN, 16'h0001);
    chk(16'(limit_event), 16'h0000);
    wr_reg(A_INTEN, 16'h0012);
    chk(16'(limit_event), 16'h0001);
    wr_reg(A_CFG, 16'h0003);
    chk(16'(fault_out_a_oe), 16'h0000);
    wr_reg(A_CFG, 16'h0001);
    chk(16'(fault_out_a_oe), 16'h0001);
    wr_reg(A_INTEN, 16'h0000);
    $display("test limits done");
  endtask
  task automatic lut_case(input logic [15:0] t, input logic [7:0] a, input logic [15:0] d);
    val[4] = t;
    wr_reg(a, d);
    frame;
    chk({res_pos_1, res_pos_0}, d);
  endtask
  task automatic t_table;
    lut_case(16'hd800, 8'h80, 16'h3c5a);
    lut_case(16'h7f00, 8'hc7, 16'hb4a5);
    lut_case(16'h1900, 8'ha0, 16'h0f1e);
    lut_case(16'h8000, 8'h80, 16'h7788);
    wr_reg(A_MANUAL, 16'h1122);
    wr_reg(A_CFG, 16'h0000);
    frame;
    chk({res_pos_1, res_pos_0}, 16'h1122);
    rchk(A_POS, 16'h1122);
    $display("test table done");
  endtask
  task automatic t_protect;
    wr_reg(A_CFG, 16'h0004);
    wr_reg(A_MANUAL, 16'h3344);
    rchk(A_MANUAL, 16'h1122);
    wr_reg(8'h00, 16'h1234);
    rchk(8'h00, 16'hffff);
    write_protect_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr_reg(A_MANUAL, 16'h3344);
    rchk(A_MANUAL, 16'h3344);
    frame;
    chk({res_pos_1, res_pos_0}, 16'h3344);
    rchk(8'h30, 16'h0000);
    write_protect_pin <= 1'b1;
    wr_reg(A_CFG, 16'h0001);
    $display("test protect done");
  endtask
  task automatic t_serial;
    logic [15:0] w;
    logic        ack;
    w = 16'h0000;
    i_twi_host.xfer(7'h20, 1'b1, w, ack);
    chk(16'(ack), 16'h0000);
    chk(w, val[0]);
    chk(w & 16'hfff0, 16'hfff0);
    w = 16'h0015;
    i_twi_host.xfer(7'h2b, 1'b0, w, ack);
    chk(16'(ack), 16'h0000);
    rchk(A_INTEN, 16'h0015);
    $display("test serial done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 t_reset;
    t_rotate;
    t_results;
    t_buffers;
    t_limits;
    t_table;
    t_protect;
    t_serial;
    tally_and_finish;
  end
  // whole run is under two thousand cycles, so 20k cycles means a hang
  initial begin
    #500_000;
    bad_count++;
    tally_and_finish;
  end
endmodule
